// file: verilog/flash_write_erase_control.sv
`timescale 1ns/1ps
module flash_write_erase_control #(
  parameter int ADDR_W = 16
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Special-function register port from the processor core
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  // Configuration register port from the processor core
  input wire logic cfg_wr,
  input wire logic [15:0] cfg_addr,
  input wire logic [7:0] cfg_wdata,
  output logic [7:0] cfg_rdata,
  // External-space move from the core
  input wire logic xmove_wr,
  input wire logic [ADDR_W-1:0] data_pointer,
  input wire logic [7:0] xmove_data,
  input wire logic irq_global_enable,
  // External RAM write path
  output logic xram_wr,
  output logic [ADDR_W-1:0] xram_addr,
  output logic [7:0] xram_wdata,
  // Compute engine status
  input wire logic ce_enable,
  input wire logic ce_busy,
  // Security and port status
  input wire logic read_protect_setting,
  input wire logic port_write_allowed_in,
  input wire logic debug_emulation_port,
  // Flash array request
  output logic flash_req,
  output flash_ctl_pkg::flash_op_t flash_op,
  output logic [ADDR_W-1:0] flash_addr,
  output logic [7:0] flash_wdata,
  output logic [5:0] flash_page
);
  logic program_write_enable;
  logic mass_erase_enable;
  logic posted_write_enable;
  logic [6:0] page_erase_address;
  logic [3:0] modify_unlock_code;
  logic ce_busy_d;
  logic next_program_write_enable;
  logic next_mass_erase_enable;
  logic next_posted_write_enable;
  logic [6:0] next_page_erase_address;
  logic [3:0] next_modify_unlock_code;
  logic unlocked;
  logic to_flash;
  logic posted_mode;
  logic posted_write_pending;
  logic slot_load;
  logic slot_drain;
  logic [ADDR_W-1:0] slot_addr;
  logic [7:0] slot_data;
  logic immediate_write;
  logic erase_cmd_wr;
  logic page_erase_go;
  logic mass_erase_go;
  logic byte_written;
  logic next_flash_req;
  flash_ctl_pkg::flash_op_t next_flash_op;
  logic [ADDR_W-1:0] next_flash_addr;
  logic [7:0] next_flash_wdata;
  logic [5:0] next_flash_page;
  logic next_xram_wr;
  logic [ADDR_W-1:0] next_xram_addr;
  logic [7:0] next_xram_wdata;

  function automatic logic sfr_hit(input logic wr, input logic [7:0] a, input logic [7:0] t);
    return wr && (a == t);
  endfunction

  assign unlocked = (modify_unlock_code == flash_ctl_pkg::UNLOCK_KEY);
  assign to_flash = xmove_wr && program_write_enable;
  assign posted_mode = posted_write_enable && ce_enable;
  // A new write while the slot is full is dropped
  assign slot_load = to_flash && unlocked && posted_mode && !posted_write_pending;
  assign slot_drain = posted_write_pending && ce_busy_d && !ce_busy;
  assign immediate_write = to_flash && unlocked && !posted_mode && !posted_write_pending;
  assign byte_written = slot_load || immediate_write;
  assign erase_cmd_wr = sfr_hit(sfr_wr, sfr_addr, flash_ctl_pkg::SFR_ERASE_CMD);
  assign page_erase_go = erase_cmd_wr && unlocked
    && (sfr_wdata == flash_ctl_pkg::ERASE_PAGE_CODE);
  assign mass_erase_go = erase_cmd_wr && unlocked && mass_erase_enable && debug_emulation_port
    && (sfr_wdata == flash_ctl_pkg::ERASE_MASS_CODE);

  posted_write_slot #(
    .ADDR_W(ADDR_W)
  ) u_slot (
    .clock(clock),
    .rst_b(rst_b),
    .load(slot_load),
    .load_addr(data_pointer),
    .load_data(xmove_data),
    .drain(slot_drain),
    .full(posted_write_pending),
    .addr(slot_addr),
    .data(slot_data)
  );

  // Control registers
  always_comb begin
    next_program_write_enable = program_write_enable;
    next_mass_erase_enable = mass_erase_enable;
    next_posted_write_enable = posted_write_enable;
    next_page_erase_address = page_erase_address;
    next_modify_unlock_code = modify_unlock_code;
    if (sfr_hit(sfr_wr, sfr_addr, flash_ctl_pkg::SFR_FLASH_CTL)) begin
      if (!irq_global_enable) begin
        next_program_write_enable = sfr_wdata[flash_ctl_pkg::PWE_BIT];
      end
      next_mass_erase_enable = sfr_wdata[flash_ctl_pkg::MEEN_BIT];
      next_posted_write_enable = sfr_wdata[flash_ctl_pkg::PSTWR_BIT];
    end
    if (sfr_hit(sfr_wr, sfr_addr, flash_ctl_pkg::SFR_PAGE_ADDR)) begin
      next_page_erase_address = sfr_wdata[flash_ctl_pkg::PGADR_LSB +: flash_ctl_pkg::PGADR_W];
    end
    if (cfg_wr && cfg_addr == flash_ctl_pkg::CFG_FLASH_STAT) begin
      next_modify_unlock_code = cfg_wdata[flash_ctl_pkg::UNLOCK_LSB +: 4];
    end
    if (byte_written) begin
      next_program_write_enable = 1'b0;
    end
    if (mass_erase_go) begin
      next_mass_erase_enable = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      program_write_enable <= 1'b0;
      mass_erase_enable <= 1'b0;
      posted_write_enable <= 1'b0;
      page_erase_address <= flash_ctl_pkg::PGADR_RESET;
      modify_unlock_code <= flash_ctl_pkg::UNLOCK_RESET;
      ce_busy_d <= 1'b0;
    end else begin
      program_write_enable <= next_program_write_enable;
      mass_erase_enable <= next_mass_erase_enable;
      posted_write_enable <= next_posted_write_enable;
      page_erase_address <= next_page_erase_address;
      modify_unlock_code <= next_modify_unlock_code;
      ce_busy_d <= ce_busy;
    end
  end

  // Flash and RAM request outputs
  always_comb begin
    next_flash_req = 1'b0;
    next_flash_op = flash_op;
    next_flash_addr = flash_addr;
    next_flash_wdata = flash_wdata;
    next_flash_page = flash_page;
    next_xram_wr = 1'b0;
    next_xram_addr = xram_addr;
    next_xram_wdata = xram_wdata;
    if (xmove_wr && !program_write_enable) begin
      next_xram_wr = 1'b1;
      next_xram_addr = data_pointer;
      next_xram_wdata = xmove_data;
    end
    if (slot_drain) begin
      next_flash_req = 1'b1;
      next_flash_op = flash_ctl_pkg::FLASH_OP_WRITE;
      next_flash_addr = slot_addr;
      next_flash_wdata = slot_data;
    end else if (immediate_write) begin
      next_flash_req = 1'b1;
      next_flash_op = flash_ctl_pkg::FLASH_OP_WRITE;
      next_flash_addr = data_pointer;
      next_flash_wdata = xmove_data;
    end else if (page_erase_go && page_erase_address <= flash_ctl_pkg::PGADR_LAST) begin
      next_flash_req = 1'b1;
      next_flash_op = flash_ctl_pkg::FLASH_OP_PAGE_ERASE;
      next_flash_page = page_erase_address[5:0];
    end else if (mass_erase_go) begin
      next_flash_req = 1'b1;
      next_flash_op = flash_ctl_pkg::FLASH_OP_MASS_ERASE;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      flash_req <= 1'b0;
      flash_op <= flash_ctl_pkg::FLASH_OP_WRITE;
      flash_addr <= '0;
      flash_wdata <= 8'h00;
      flash_page <= 6'h00;
      xram_wr <= 1'b0;
      xram_addr <= '0;
      xram_wdata <= 8'h00;
    end else begin
      flash_req <= next_flash_req;
      flash_op <= next_flash_op;
      flash_addr <= next_flash_addr;
      flash_wdata <= next_flash_wdata;
      flash_page <= next_flash_page;
      xram_wr <= next_xram_wr;
      xram_addr <= next_xram_addr;
      xram_wdata <= next_xram_wdata;
    end
  end

  // Register reads
  always_comb begin
    sfr_rdata = 8'h00;
    if (sfr_addr == flash_ctl_pkg::SFR_FLASH_CTL) begin
      sfr_rdata[flash_ctl_pkg::PWE_BIT] = program_write_enable;
      sfr_rdata[flash_ctl_pkg::MEEN_BIT] = mass_erase_enable;
      sfr_rdata[flash_ctl_pkg::PSTWR_BIT] = posted_write_enable;
      sfr_rdata[flash_ctl_pkg::PEND_BIT] = posted_write_pending;
    end
  end

  always_comb begin
    cfg_rdata = 8'h00;
    if (cfg_addr == flash_ctl_pkg::CFG_FLASH_STAT) begin
      cfg_rdata[flash_ctl_pkg::WRE_BIT] = port_write_allowed_in;
      cfg_rdata[flash_ctl_pkg::RDE_BIT] = !read_protect_setting;
      cfg_rdata[flash_ctl_pkg::UNLOCK_LSB +: 4] = modify_unlock_code;
    end
  end
endmodule // flash_write_erase_control

// file: verilog/flash_ctl_pkg.sv
package flash_ctl_pkg;
  // Special-function register addresses
  localparam logic [7:0] SFR_ERASE_CMD = 8'h94;
  localparam logic [7:0] SFR_FLASH_CTL = 8'hB2;
  localparam logic [7:0] SFR_PAGE_ADDR = 8'hB7;
  // Configuration register address
  localparam logic [15:0] CFG_FLASH_STAT = 16'h2702;
  // Fields of the flash control register
  localparam int PWE_BIT = 0;
  localparam int MEEN_BIT = 1;
  localparam int PSTWR_BIT = 2;
  localparam int PEND_BIT = 3;
  // Page address field
  localparam int PGADR_LSB = 1;
  localparam int PGADR_W = 7;
  localparam logic [6:0] PGADR_RESET = 7'h00;
  localparam logic [6:0] PGADR_LAST = 7'h3F;
  // Flash status register fields
  localparam int WRE_BIT = 1;
  localparam int RDE_BIT = 2;
  localparam int UNLOCK_LSB = 4;
  localparam logic [3:0] UNLOCK_RESET = 4'h0;
  localparam logic [3:0] UNLOCK_KEY = 4'h2;
  // Erase command codes
  localparam logic [7:0] ERASE_PAGE_CODE = 8'h55;
  localparam logic [7:0] ERASE_MASS_CODE = 8'hAA;
  typedef enum logic [1:0] {
    FLASH_OP_WRITE,
    FLASH_OP_PAGE_ERASE,
    FLASH_OP_MASS_ERASE
  } flash_op_t;
endpackage

// file: verilog/posted_write_slot.sv
`timescale 1ns/1ps
// One-entry holding slot for a posted flash byte write
module posted_write_slot #(
  parameter int ADDR_W = 16
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Fill side
  input wire logic load,
  input wire logic [ADDR_W-1:0] load_addr,
  input wire logic [7:0] load_data,
  // Drain side
  input wire logic drain,
  output logic full,
  output logic [ADDR_W-1:0] addr,
  output logic [7:0] data
);
  logic next_full;
  logic [ADDR_W-1:0] next_addr;
  logic [7:0] next_data;

  always_comb begin
    next_full = full;
    next_addr = addr;
    next_data = data;
    if (drain) begin
      next_full = 1'b0;
    end
    if (load && !full) begin
      next_full = 1'b1;
      next_addr = load_addr;
      next_data = load_data;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      full <= 1'b0;
      addr <= '0;
      data <= 8'h00;
    end else begin
      full <= next_full;
      addr <= next_addr;
      data <= next_data;
    end
  end
endmodule // posted_write_slot

// file: tb/flash_ctl_checker.sv
`timescale 1ns/1ps
module flash_ctl_checker (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Register ports
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic [15:0] cfg_addr,
  input wire logic [7:0] cfg_rdata,
  // Moves and status
  input wire logic xmove_wr,
  input wire logic irq_global_enable,
  input wire logic xram_wr,
  input wire logic ce_enable,
  input wire logic ce_busy,
  input wire logic read_protect_setting,
  input wire logic port_write_allowed_in,
  // Flash request
  input wire logic flash_req,
  input wire flash_ctl_pkg::flash_op_t flash_op
);
  logic at_ctl, pwe, pst, pend, stat, unl, wr_op, mv;
  assign at_ctl = sfr_addr == flash_ctl_pkg::SFR_FLASH_CTL;
  assign pwe = sfr_rdata[flash_ctl_pkg::PWE_BIT];
  assign pst = sfr_rdata[flash_ctl_pkg::PSTWR_BIT];
  assign pend = sfr_rdata[flash_ctl_pkg::PEND_BIT];
  assign stat = cfg_addr == flash_ctl_pkg::CFG_FLASH_STAT;
  assign unl = stat && cfg_rdata[7:4] == flash_ctl_pkg::UNLOCK_KEY;
  assign wr_op = flash_req && flash_op == flash_ctl_pkg::FLASH_OP_WRITE;
  assign mv = at_ctl && xmove_wr && !sfr_wr;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  a_status_bits: assert property (stat |->
    cfg_rdata[2:1] == {!read_protect_setting, port_write_allowed_in}) else $error("status bits");
  a_pwe_off_ram: assert property (mv && !pwe |=> xram_wr) else $error("ram move lost");
  a_pwe_on_flash: assert property (mv && pwe && !pend && !(pst && ce_enable) && unl
    |=> wr_op && !xram_wr && (!at_ctl || !pwe)) else $error("flash byte write");
  a_lock_blocks: assert property (stat && !unl && at_ctl && !pend |=> !flash_req)
    else $error("locked flash changed");
  a_posted_hold: assert property (mv && pwe && pst && ce_enable && ce_busy && unl
    |=> !flash_req && (!at_ctl || pend)) else $error("posted write not held");
  a_drain_fall: assert property (at_ctl && pend && !ce_busy && $past(ce_busy)
    |=> wr_op && (!at_ctl || !pend)) else $error("queued write not drained");
  a_pwe_irq_lock: assert property (sfr_wr && at_ctl && irq_global_enable && !pwe
    |=> !at_ctl || !pwe) else $error("enable written with interrupts on");
  a_erase_codes: assert property (sfr_wr && sfr_addr == flash_ctl_pkg::SFR_ERASE_CMD
    && sfr_wdata != flash_ctl_pkg::ERASE_PAGE_CODE && !xmove_wr
    && sfr_wdata != flash_ctl_pkg::ERASE_MASS_CODE && !(!ce_busy && $past(ce_busy))
    |=> !flash_req) else $error("unknown erase code acted on");
endmodule // flash_ctl_checker
bind flash_write_erase_control flash_ctl_checker i_chk (.clock(clock), .rst_b(rst_b),
  .sfr_wr(sfr_wr), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
  .cfg_addr(cfg_addr), .cfg_rdata(cfg_rdata), .xmove_wr(xmove_wr),
  .irq_global_enable(irq_global_enable), .xram_wr(xram_wr), .ce_enable(ce_enable),
  .ce_busy(ce_busy), .read_protect_setting(read_protect_setting),
  .port_write_allowed_in(port_write_allowed_in), .flash_req(flash_req), .flash_op(flash_op));

// file: tb/flash_array_model.sv
`timescale 1ns/1ps
// Flash array side: logs every request it is handed
module flash_array_model (
  // Clock
  input wire logic clock,
  // Request from the controller
  input wire logic flash_req,
  input wire flash_ctl_pkg::flash_op_t flash_op,
  input wire logic [15:0] flash_addr,
  input wire logic [7:0] flash_wdata,
  input wire logic [5:0] flash_page,
  // Log of the last operation
  output logic [7:0] req_count,
  output flash_ctl_pkg::flash_op_t last_op,
  output logic [15:0] last_addr,
  output logic [7:0] last_data,
  output logic [5:0] last_page
);
  initial req_count = 8'h00;
  always @(posedge clock) begin
    if (flash_req === 1'b1) begin
      req_count <= req_count + 8'h01;
      last_op <= flash_op;
      last_addr <= flash_addr;
      last_data <= flash_wdata;
      last_page <= flash_page;
    end
  end
endmodule // flash_array_model

// file: tb/tb.sv
`timescale 1ns/1ps
module tb;
  logic clock = 1'b0, rst_b = 1'b0, sfr_wr = 1'b0, cfg_wr = 1'b0, xmove_wr = 1'b0;
  logic irq_global_enable = 1'b0, ce_enable = 1'b0, ce_busy = 1'b0, read_protect_setting = 1'b0;
  logic port_write_allowed_in = 1'b1, debug_emulation_port = 1'b0;
  logic [7:0] sfr_addr = flash_ctl_pkg::SFR_FLASH_CTL, sfr_wdata = 8'h00, xmove_data = 8'h00;
  logic [15:0] cfg_addr = flash_ctl_pkg::CFG_FLASH_STAT, data_pointer = 16'h0000;
  logic [7:0] cfg_wdata = 8'h00, sfr_rdata, cfg_rdata, xram_wdata, flash_wdata, req_count, ldata;
  logic [15:0] xram_addr, flash_addr, laddr, ram_addr;
  logic [7:0] ram_data;
  logic [5:0] flash_page, lpage;
  logic xram_wr, flash_req;
  flash_ctl_pkg::flash_op_t flash_op, lop;
  logic [7:0] codes [5] = '{8'h00, 8'h54, 8'h56, 8'hAB, 8'hFF};
  int errors = 0;
  int cmp_count = 0;
  always #12.5 clock = ~clock;
  flash_write_erase_control i_dut (.clock(clock), .rst_b(rst_b), .sfr_wr(sfr_wr),
    .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .cfg_wr(cfg_wr),
    .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .xmove_wr(xmove_wr),
    .data_pointer(data_pointer), .xmove_data(xmove_data), .irq_global_enable(irq_global_enable),
    .xram_wr(xram_wr), .xram_addr(xram_addr), .xram_wdata(xram_wdata), .ce_enable(ce_enable),
    .ce_busy(ce_busy), .read_protect_setting(read_protect_setting),
    .port_write_allowed_in(port_write_allowed_in), .debug_emulation_port(debug_emulation_port),
    .flash_req(flash_req), .flash_op(flash_op), .flash_addr(flash_addr),
    .flash_wdata(flash_wdata), .flash_page(flash_page));
  flash_array_model i_flash (.clock(clock), .flash_req(flash_req), .flash_op(flash_op),
    .flash_addr(flash_addr), .flash_wdata(flash_wdata), .flash_page(flash_page),
    .req_count(req_count), .last_op(lop), .last_addr(laddr), .last_data(ldata),
    .last_page(lpage));
  always @(posedge clock) begin
    if (xram_wr === 1'b1) begin
      ram_addr <= xram_addr;
      ram_data <= xram_wdata;
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #2;
  endtask
  task automatic sfr_w(input logic [7:0] a, input logic [7:0] d);
    sfr_wr = 1'b1;
    sfr_addr = a;
    sfr_wdata = d;
    tick(1);
    sfr_wr = 1'b0;
    sfr_addr = flash_ctl_pkg::SFR_FLASH_CTL;
    // Let an edge pass so that a following call never re-raises the strobe in this step
    tick(1);
  endtask
  task automatic xmv(input logic [15:0] a, input logic [7:0] d);
    xmove_wr = 1'b1;
    data_pointer = a;
    xmove_data = d;
    tick(1);
    xmove_wr = 1'b0;
    tick(2);
  endtask
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    #50000;
    errors++;
    conclude();
  end
  initial begin
    tick(6);
    rst_b = 1'b1;
    tick(1);
    check("ctl", sfr_rdata, 8'h00);
    check("stat", cfg_rdata, 8'h06);
    read_protect_setting = 1'b1;
    port_write_allowed_in = 1'b0;
    tick(1);
    check("stat", cfg_rdata, 8'h00);
    sfr_w(flash_ctl_pkg::SFR_FLASH_CTL, 8'h01);
    xmv(16'h1234, 8'hA5);
    check("count", req_count, 8'h00);
    cfg_wr = 1'b1;
    cfg_wdata = 8'h20;
    tick(1);
    cfg_wr = 1'b0;
    check("unlock", cfg_rdata, 8'h20);
    sfr_w(flash_ctl_pkg::SFR_FLASH_CTL, 8'h01);
    xmv(16'h1234, 8'hA5);
    check("op", lop, flash_ctl_pkg::FLASH_OP_WRITE);
    check("addr", laddr, 16'h1234);
    check("data", ldata, 8'hA5);
    check("ctl", sfr_rdata, 8'h00);
    xmv(16'h0042, 8'h11);
    check("ram", ram_addr, 16'h0042);
    check("ram data", ram_data, 8'h11);
    irq_global_enable = 1'b1;
    sfr_w(flash_ctl_pkg::SFR_FLASH_CTL, 8'h01);
    irq_global_enable = 1'b0;
    check("ctl", sfr_rdata, 8'h00);
    sfr_w(flash_ctl_pkg::SFR_PAGE_ADDR, 8'h7E);
    sfr_w(flash_ctl_pkg::SFR_ERASE_CMD, flash_ctl_pkg::ERASE_PAGE_CODE);
    tick(2);
    check("op", lop, flash_ctl_pkg::FLASH_OP_PAGE_ERASE);
    check("page", lpage, 6'h3F);
    foreach (codes[i]) sfr_w(flash_ctl_pkg::SFR_ERASE_CMD, codes[i]);
    tick(2);
    check("count", req_count, 8'h02);
    debug_emulation_port = 1'b1;
    sfr_w(flash_ctl_pkg::SFR_FLASH_CTL, 8'h02);
    sfr_w(flash_ctl_pkg::SFR_ERASE_CMD, flash_ctl_pkg::ERASE_MASS_CODE);
    tick(2);
    check("op", lop, flash_ctl_pkg::FLASH_OP_MASS_ERASE);
    ce_enable = 1'b1;
    ce_busy = 1'b1;
    sfr_w(flash_ctl_pkg::SFR_FLASH_CTL, 8'h05);
    xmv(16'h0100, 8'h3C);
    check("count", req_count, 8'h03);
    check("pend", sfr_rdata[3], 1'b1);
    sfr_w(flash_ctl_pkg::SFR_FLASH_CTL, 8'h05);
    xmv(16'h0200, 8'h77);
    check("count", req_count, 8'h03);
    ce_busy = 1'b0;
    tick(2);
    check("count", req_count, 8'h04);
    check("addr", laddr, 16'h0100);
    check("data", ldata, 8'h3C);
    check("ctl", sfr_rdata, 8'h05);
    // Reset in mid-run: the queue, the enables and the page address all return to zero
    rst_b = 1'b0;
    tick(1);
    rst_b = 1'b1;
    tick(1);
    check("ctl", sfr_rdata, 8'h00);
    cfg_wr = 1'b1;
    cfg_wdata = 8'h20;
    tick(1);
    cfg_wr = 1'b0;
    sfr_w(flash_ctl_pkg::SFR_ERASE_CMD, flash_ctl_pkg::ERASE_PAGE_CODE);
    tick(2);
    check("count", req_count, 8'h05);
    check("page", lpage, 6'h00);
    sfr_w(flash_ctl_pkg::SFR_PAGE_ADDR, 8'h80);
    sfr_w(flash_ctl_pkg::SFR_ERASE_CMD, flash_ctl_pkg::ERASE_PAGE_CODE);
    tick(2);
    check("count", req_count, 8'h05);
    conclude();
  end
endmodule // tb
